// file: hw/codec_ctl_device.sv
// Codec control interface: instruction decoder, programming registers, receive gating
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module codec_ctl_device
  import codec_ctl_pkg::*;
(
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // Control link
  codec_ctl_if.device LINK,
  // Receive PCM ports
  input wire logic [7:0] PCM_RECEIVE_INPUT0,
  input wire logic [7:0] PCM_RECEIVE_INPUT1,
  input wire logic [5:0] PCM_RX_SLOT,
  input wire logic PCM_RX_VALID,
  // Receive output and state
  output logic [7:0] RECEIVE_ANALOG_OUTPUT,
  output logic RECEIVE_OUTPUT_VALID,
  output logic [7:0] RX_GAIN_CODE,
  output logic POWERED_DOWN,
  output logic DELAYED_TIMING,
  output logic BYTE_PHASE
);
  byte_state_type byte_state;
  logic [7:0] prog [0:15];
  logic [3:0] held_addr;
  logic held_read;
  logic powered_down;
  logic dev_reset;
  logic [3:0] new_addr;
  logic first_valid;
  logic addr_used;
  logic [7:0] rx_sample;
  logic rx_accept;

  // Power-up and hard reset share one synchronous reset path
  assign dev_reset = RST | LINK.hard_reset_input;
  assign new_addr = LINK.ctl_byte[ADDR_MSB:ADDR_LSB];
  assign first_valid = LINK.ctl_strobe && byte_state == expect_first;
  // Reserved codes are decoded as unused so they cannot corrupt state
  assign addr_used = USED_ADDR_MASK[held_addr];

  // Byte position within an instruction
  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      byte_state <= expect_first;
    end else if (CE && LINK.ctl_strobe) begin
      unique case (byte_state)
        expect_first: begin
          // One-byte power instruction leaves the counter at first byte
          if (!LINK.ctl_byte[SINGLE_BIT]) begin
            byte_state <= expect_second;
          end
        end
        expect_second: begin
          byte_state <= expect_first;
        end
      endcase
    end
  end

  // Address and direction held from the first byte
  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      held_addr <= 4'h0;
      held_read <= 1'b0;
    end else if (CE && first_valid) begin
      held_addr <= new_addr;
      held_read <= LINK.ctl_byte[READ_BIT];
    end
  end

  // Every first byte carries the power control bit
  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      powered_down <= POWER_DOWN_RESET;
    end else if (CE && first_valid) begin
      powered_down <= LINK.ctl_byte[POWER_BIT];
    end
  end

  // Programming registers; reset restores defaults, so software must rewrite them
  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      for (int i = 0; i < 16; i++) begin
        prog[i] <= PROG_RESET;
      end
    end else if (CE && LINK.ctl_strobe && byte_state == expect_second) begin
      if (!held_read && addr_used) begin
        prog[held_addr] <= LINK.ctl_byte;
      end
    end
  end

  // Read answer follows the first byte of a read instruction
  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      LINK.read_byte <= 8'h00;
      LINK.read_valid <= 1'b0;
    end else if (CE) begin
      LINK.read_valid <= 1'b0;
      if (first_valid && LINK.ctl_byte[READ_BIT] && !LINK.ctl_byte[SINGLE_BIT]) begin
        // Reserved addresses read back as zero
        LINK.read_byte <= USED_ADDR_MASK[new_addr] ? prog[new_addr] : 8'h00;
        LINK.read_valid <= 1'b1;
      end
    end
  end

  // Receive path gating
  assign rx_sample = prog[ADDR_RX_SLOT][RX_PORT_BIT] ? PCM_RECEIVE_INPUT1
                                                      : PCM_RECEIVE_INPUT0;
  assign rx_accept = PCM_RX_VALID && !powered_down
                     && prog[ADDR_RX_SLOT][RX_ENABLE_BIT]
                     && PCM_RX_SLOT == prog[ADDR_RX_SLOT][SLOT_MSB:0];

  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      RECEIVE_ANALOG_OUTPUT <= 8'h00;
      RECEIVE_OUTPUT_VALID <= 1'b0;
    end else if (CE) begin
      RECEIVE_OUTPUT_VALID <= rx_accept;
      if (!prog[ADDR_RX_SLOT][RX_ENABLE_BIT] || powered_down) begin
        RECEIVE_ANALOG_OUTPUT <= 8'h00;
      end else if (rx_accept) begin
        // Off code mutes rather than attenuating
        RECEIVE_ANALOG_OUTPUT <= prog[ADDR_RX_GAIN] == GAIN_OFF ? 8'h00 : rx_sample;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (dev_reset) begin
      RX_GAIN_CODE <= GAIN_OFF;
      POWERED_DOWN <= POWER_DOWN_RESET;
      DELAYED_TIMING <= 1'b0;
      BYTE_PHASE <= 1'b0;
    end else if (CE) begin
      RX_GAIN_CODE <= prog[ADDR_RX_GAIN];
      POWERED_DOWN <= powered_down;
      DELAYED_TIMING <= prog[ADDR_CONTROL][TIMING_BIT];
      BYTE_PHASE <= byte_state == expect_second;
    end
  end
endmodule

// file: hw/codec_ctl_pkg.sv
// Shared constants for the codec control instruction link and both of its ends
package codec_ctl_pkg;
  // First instruction byte layout
  localparam int POWER_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 3;
  localparam int READ_BIT = 2;
  localparam int SINGLE_BIT = 0;
  // Programming register addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RX_GAIN = 4'h4;
  localparam logic [3:0] ADDR_RX_SLOT = 4'h5;
  localparam logic [3:0] ADDR_RESERVED_LOW = 4'h3;
  localparam logic [3:0] ADDR_RESERVED_FIRST = 4'hB;
  // Mask of the ten used addresses, bit n for address n
  localparam logic [15:0] USED_ADDR_MASK = 16'h07F7;
  // Field positions
  localparam int TIMING_BIT = 3;
  localparam int RX_ENABLE_BIT = 7;
  localparam int RX_PORT_BIT = 6;
  localparam int SLOT_MSB = 5;
  // Values after reset
  localparam logic [7:0] PROG_RESET = 8'h00;
  localparam logic POWER_DOWN_RESET = 1'b1;
  localparam logic [7:0] GAIN_OFF = 8'h00;
  // Hard reset pulse length from the controller
  localparam int HARD_RESET_NS = 20;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HARD_RESET_CYCLES = (HARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Controller register offsets
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_RESET = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_READBACK = 4'hC;

  typedef enum logic {expect_first, expect_second} byte_state_type;
  typedef enum logic [1:0] {send_idle, send_first, send_second, send_reset} send_state_type;
endpackage

// file: hw/codec_ctl_if.sv
// Byte-wide control instruction link between controller and codec
`timescale 1ns/1ps
interface codec_ctl_if;
  logic [7:0] ctl_byte;
  logic ctl_strobe;
  logic hard_reset_input;
  logic [7:0] read_byte;
  logic read_valid;

  modport device (
    input ctl_byte, ctl_strobe, hard_reset_input,
    output read_byte, read_valid
  );
  modport controller (
    output ctl_byte, ctl_strobe, hard_reset_input,
    input read_byte, read_valid
  );
endinterface

// file: hw/codec_ctl_host.sv
// Controller end: turns register writes into control instructions and resets
`timescale 1ns/1ps
module codec_ctl_host
  import codec_ctl_pkg::*;
(
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // Software port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Control link
  codec_ctl_if.controller LINK
);
  send_state_type send_state;
  logic [7:0] first_byte;
  logic [7:0] second_byte;
  logic [7:0] readback;
  logic reserved_error;
  logic [15:0] stale;
  logic [$clog2(HARD_RESET_CYCLES+1)-1:0] reset_count;
  logic busy;
  logic [3:0] cmd_addr;
  logic cmd_take;

  assign busy = send_state != send_idle;
  assign cmd_addr = WDATA[8+ADDR_MSB:8+ADDR_LSB];
  assign cmd_take = WR && ADDR == REG_COMMAND && !busy;

  // Instruction sequencer; reserved addresses never leave the controller
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      send_state <= send_idle;
      first_byte <= 8'h00;
      second_byte <= 8'h00;
      reset_count <= '0;
    end else if (CE) begin
      unique case (send_state)
        send_idle: begin
          if (cmd_take && USED_ADDR_MASK[cmd_addr]) begin
            first_byte <= WDATA[15:8];
            second_byte <= WDATA[7:0];
            send_state <= send_first;
          end else if (WR && ADDR == REG_RESET && WDATA[0]) begin
            // Resync by hard reset, never by the one-byte instruction
            reset_count <= ($clog2(HARD_RESET_CYCLES+1))'(HARD_RESET_CYCLES);
            send_state <= send_reset;
          end
        end
        send_first: begin
          send_state <= first_byte[SINGLE_BIT] ? send_idle : send_second;
        end
        send_second: begin
          send_state <= send_idle;
        end
        send_reset: begin
          reset_count <= reset_count - 1'b1;
          if (reset_count == 1) begin
            send_state <= send_idle;
          end
        end
      endcase
    end
  end

  always_comb begin
    LINK.ctl_strobe = CE && (send_state == send_first || send_state == send_second);
    LINK.ctl_byte = send_state == send_second ? second_byte : first_byte;
    LINK.hard_reset_input = send_state == send_reset;
  end

  // Sticky error for a refused reserved address; set wins over clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      reserved_error <= 1'b0;
    end else if (CE) begin
      if (cmd_take && !USED_ADDR_MASK[cmd_addr]) begin
        reserved_error <= 1'b1;
      end else if (WR && ADDR == REG_STATUS && WDATA[1]) begin
        reserved_error <= 1'b0;
      end
    end
  end

  // Registers not yet rewritten since the last reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stale <= USED_ADDR_MASK;
    end else if (CE) begin
      if (send_state == send_reset) begin
        stale <= USED_ADDR_MASK;
      end else if (send_state == send_second && !first_byte[READ_BIT]) begin
        stale[first_byte[ADDR_MSB:ADDR_LSB]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      readback <= 8'h00;
    end else if (CE && LINK.read_valid) begin
      readback <= LINK.read_byte;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= 32'h0000_0000;
      if (RD) begin
        unique case (ADDR)
          REG_STATUS: RDATA <= {stale, 14'h0000, reserved_error, busy};
          REG_READBACK: RDATA <= {24'h000000, readback};
          default: RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: tb/codec_ctl_properties.sv
// Link checker for the codec control instruction interface
`timescale 1ns/1ps
module codec_ctl_properties
  import codec_ctl_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Link signals
  input wire logic [7:0] ctl_byte,
  input wire logic ctl_strobe,
  input wire logic hard_reset_input,
  input wire logic [7:0] read_byte,
  input wire logic read_valid
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic second;
  wire first_strobe = ctl_strobe && !second;
  wire [3:0] addr = ctl_byte[ADDR_MSB:ADDR_LSB];
  // Mirror of the byte counter, so first bytes can be told from second ones
  always_ff @(posedge SYS_CLK) begin
    if (RST || hard_reset_input) begin
      second <= 1'b0;
    end else if (ctl_strobe) begin
      second <= !second && !ctl_byte[SINGLE_BIT];
    end
  end
  property p_reset_idle;
    $fell(RST) |-> !ctl_strobe && !hard_reset_input && !read_valid;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
  property p_pair;
    first_strobe && !ctl_byte[SINGLE_BIT] |=> ctl_strobe;
  endproperty
  a_pair: assert property (p_pair) else $error("second byte missing");
  property p_single;
    first_strobe && ctl_byte[SINGLE_BIT] |=> !ctl_strobe;
  endproperty
  a_single: assert property (p_single) else $error("extra byte after one-byte order");
  property p_no_reserved;
    first_strobe |-> !(addr == ADDR_RESERVED_LOW || addr >= ADDR_RESERVED_FIRST);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved address sent");
  property p_read_answer;
    first_strobe && ctl_byte[READ_BIT] && !ctl_byte[SINGLE_BIT] |=> read_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_cause;
    read_valid |-> $past(first_strobe && ctl_byte[READ_BIT]);
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("answer without read");
  property p_read_pulse;
    read_valid |=> !read_valid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("answer longer than a cycle");
  property p_hard_len;
    $rose(hard_reset_input) |-> hard_reset_input [*5] ##1 !hard_reset_input;
  endproperty
  a_hard_len: assert property (p_hard_len) else $error("hard reset pulse length wrong");
  property p_quiet;
    hard_reset_input |-> !ctl_strobe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("byte sent during hard reset");
endmodule

// file: tb/codec_control_instruction_logic_bench.sv
// Testbench joining controller and codec ends over the control link
`timescale 1ns/1ps
module codec_control_instruction_logic_bench import codec_ctl_pkg::*;;
  logic sys_clk, rst, wr, rd, pvalid;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, s;
  logic [7:0] pcm0, pcm1, rx_out, gain;
  logic [5:0] slot;
  logic rx_vld, pwr_dn, dly, phase;
  int num_errors = 0;
  int checks_done = 0;
  codec_ctl_if link();
  codec_ctl_host i_codec_ctl_host(.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link));
  codec_ctl_device i_codec_ctl_device(.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .LINK(link),
    .PCM_RECEIVE_INPUT0(pcm0), .PCM_RECEIVE_INPUT1(pcm1), .PCM_RX_SLOT(slot),
    .PCM_RX_VALID(pvalid), .RECEIVE_ANALOG_OUTPUT(rx_out), .RECEIVE_OUTPUT_VALID(rx_vld),
    .RX_GAIN_CODE(gain), .POWERED_DOWN(pwr_dn), .DELAYED_TIMING(dly), .BYTE_PHASE(phase));
  codec_ctl_properties i_codec_ctl_properties(.SYS_CLK(sys_clk), .RST(rst),
    .ctl_byte(link.ctl_byte), .ctl_strobe(link.ctl_strobe),
    .hard_reset_input(link.hard_reset_input), .read_byte(link.read_byte),
    .read_valid(link.read_valid));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle;
    s = 32'h1;
    for (int n = 0; n < 50 && s[0] !== 1'b0; n++) rd_reg(REG_STATUS, s);
    if (s[0] !== 1'b0) begin
      num_errors++;
      $display("[FAIL] t=%0t busy=%h exp=%h", $time, s[0], 1'b0);
      wrap_up();
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2);
    wr_reg(REG_COMMAND, {16'h0000, b1, b2});
    wait_idle();
  endtask
  task automatic pcm(input logic [5:0] sl, input logic ev, input logic [7:0] eo);
    @(posedge sys_clk);
    slot <= sl;
    pvalid <= 1'b1;
    @(posedge sys_clk);
    pvalid <= 1'b0;
    #1 chk(rx_vld, ev);
    if (ev) chk(rx_out, eo);
  endtask
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
    pcm0 = 8'hA5; pcm1 = 8'h5A; slot = 6'h00; pvalid = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 chk(pwr_dn, 1'b1);
    chk({gain, dly}, 9'h000);
    chk(phase, 1'b0);
    rd_reg(REG_STATUS, s);
    chk(s, 32'h07F70000);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      cmd(8'h00, {4'h0, i[0], 3'h0});
      chk(pwr_dn, 1'b0);
      chk(dly, i[0]);
    end
    rd_reg(REG_STATUS, s);
    chk(s[31:16], 16'h07F6);
    $display("test power and timing done");
    cmd(8'h20, 8'h80);
    cmd(8'h24, 8'h00);
    rd_reg(REG_READBACK, s);
    chk(s[7:0], 8'h80);
    cmd(8'h28, 8'hC3);
    pcm(6'h03, 1'b1, 8'h5A);
    pcm(6'h04, 1'b0, 8'h00);
    cmd(8'h28, 8'h83);
    pcm(6'h03, 1'b1, 8'hA5);
    cmd(8'h28, 8'h03);
    pcm(6'h03, 1'b0, 8'h00);
    cmd(8'h28, 8'h83);
    cmd(8'h20, GAIN_OFF);
    pcm(6'h03, 1'b1, 8'h00);
    $display("test receive path done");
    for (int i = 11; i < 17; i++) begin
      wr_reg(REG_COMMAND, {16'h0, 1'b0, (i == 16) ? 4'h3 : i[3:0], 11'h0});
      rd_reg(REG_STATUS, s);
      chk(s[1:0], 2'b10);
      wr_reg(REG_STATUS, 32'h2);
    end
    $display("test reserved addresses done");
    cmd(8'h81, 8'h00);
    chk({pwr_dn, phase}, 2'b10);
    wr_reg(REG_RESET, 32'h1);
    wait_idle();
    chk({pwr_dn, gain}, 9'h100);
    rd_reg(REG_STATUS, s);
    chk(s[31:16], 16'h07F7);
    cmd(8'h20, 8'h44);
    chk(gain, 8'h44);
    $display("test hard reset done");
    wrap_up();
  end
endmodule
